/* hw/gear_scaler_consts.vh */
/*
 * Constants for the electronic gear scaler: reset values, encoder resolutions
 * and the quadrature factor. Assumes inclusion by the scaler module only.
 */
`ifndef GEAR_SCALER_CONSTS_VH
`define GEAR_SCALER_CONSTS_VH
`define NUM_RESET 16'h0004
`define DEN_RESET 16'h0001
`define QUAD_SHIFT 2
`define DIV_STEPS 5'h11
`define DIV_LAST 5'h01
`define ENC_SEL_13 2'h0
`define ENC_SEL_16 2'h1
`define ENC_SEL_17 2'h2
`define ENC_PPR_13 18'h00800
`define ENC_PPR_16 18'h04000
`define ENC_PPR_17 18'h08000
`endif

/* hw/electronic_gear_scaler.v */
/*
 * Electronic gear scaler: turns reference pulses into encoder-count travel
 * through a numerator/denominator ratio, carrying the remainder forward.
 * Assumes reference pulses and settings come from logic on clk_in, and that
 * the configuring party keeps the ratio legal and reduced.
 */
// Contract
// - Each reference pulse taken while idle is scaled by a programmable ratio into motor travel; pulses during a division are dropped.
// - One reference pulse counts as exactly one reference unit before scaling.
// - Numerator and denominator hold 1 to 65535, reset to 4 and 1.
// - Motor position is kept in encoder counts, four times pulses per revolution.
// - Encoder resolutions 2048, 16384 and 32768 pulses per revolution are supported.
`timescale 1ns/1ps
`include "gear_scaler_consts.vh"
module electronic_gear_scaler (
  input wire clk_in,
  input wire srst_in,
  input wire ref_pulse_in,
  input wire ref_dir_in,
  input wire num_wr_in,
  input wire den_wr_in,
  input wire [15:0] wr_data_in,
  input wire [1:0] enc_sel_in,
  output reg [15:0] gear_ratio_numerator_out,
  output reg [15:0] gear_ratio_denominator_out,
  output reg [15:0] step_counts_out,
  output reg step_valid_out,
  output reg step_dir_out,
  output reg [31:0] motor_pos_out,
  output wire [17:0] counts_per_rev_out,
  output wire busy_out
);
  localparam ST_IDLE = 2'b01;
  localparam ST_DIV = 2'b10;
  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [16:0] dvd_q;
  reg [16:0] dvd_d;
  reg [15:0] part_q;
  reg [15:0] part_d;
  reg [15:0] quot_q;
  reg [15:0] quot_d;
  reg [4:0] bit_q;
  reg [4:0] bit_d;
  reg dir_q;
  reg dir_d;
  reg [15:0] rem_q;
  reg [15:0] rem_d;
  reg [15:0] num_d;
  reg [15:0] den_d;
  reg [15:0] step_counts_d;
  reg step_valid_d;
  reg step_dir_d;
  reg [31:0] motor_pos_d;
  reg [17:0] ppr;
  wire idle;
  wire take;
  wire last_step;
  wire fits;
  wire [16:0] trial;
  wire [16:0] den_ext;
  wire [16:0] diff;
  wire [15:0] part_next;
  wire [15:0] quot_next;
  wire [16:0] start_dvd;
  wire [19:0] cpr_wide;
  wire [31:0] step_ext;

  assign idle = (state_q == ST_IDLE);
  assign busy_out = state_q[1];
  assign take = ref_pulse_in && idle;
  assign last_step = (state_q == ST_DIV) && (bit_q == `DIV_LAST);

  assign cpr_wide = {2'b00, ppr} << `QUAD_SHIFT;
  assign counts_per_rev_out = cpr_wide[17:0];

  always @* begin
    case (enc_sel_in)
      `ENC_SEL_13: ppr = `ENC_PPR_13;
      `ENC_SEL_16: ppr = `ENC_PPR_16;
      `ENC_SEL_17: ppr = `ENC_PPR_17;
      default: ppr = `ENC_PPR_13;
    endcase
  end

  // Ratio division step.
  // The partial remainder stays below the denominator, so 16 bits hold it and the trial
  // needs one bit more; one dividend bit per cycle trades latency for area.
  assign trial = {part_q, dvd_q[16]};
  assign den_ext = {1'b0, gear_ratio_denominator_out};
  assign fits = (trial >= den_ext);
  assign diff = trial - den_ext;
  assign part_next = fits ? diff[15:0] : trial[15:0];
  // The seventeenth quotient bit is dropped: it needs a sum above 65535 over a
  // denominator of 1, and the carried remainder is then 0 except on the first pulse after a change to it.
  assign quot_next = {quot_q[14:0], fits};
  assign start_dvd = {1'b0, gear_ratio_numerator_out} + {1'b0, rem_q};
  assign step_ext = {16'h0000, step_counts_out};

  always @* begin
    num_d = gear_ratio_numerator_out;
    den_d = gear_ratio_denominator_out;
    // Zero is refused.
    // Writes are taken only while idle, and dropped otherwise, so the ratio never changes under a running division.
    if (num_wr_in && idle && wr_data_in != 16'h0000) begin
      num_d = wr_data_in;
    end
    if (den_wr_in && idle && wr_data_in != 16'h0000) begin
      den_d = wr_data_in;
    end
  end

  always @* begin
    state_d = state_q;
    dvd_d = dvd_q;
    part_d = part_q;
    quot_d = quot_q;
    bit_d = bit_q;
    dir_d = dir_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          dvd_d = start_dvd;
          part_d = 16'h0000;
          quot_d = 16'h0000;
          bit_d = `DIV_STEPS;
          dir_d = ref_dir_in;
          state_d = ST_DIV;
        end
      end
      ST_DIV: begin
        dvd_d = {dvd_q[15:0], 1'b0};
        part_d = part_next;
        quot_d = quot_next;
        bit_d = bit_q - 5'h01;
        if (bit_q == `DIV_LAST) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @* begin
    step_valid_d = 1'b0;
    step_counts_d = step_counts_out;
    step_dir_d = step_dir_out;
    rem_d = rem_q;
    motor_pos_d = motor_pos_out;
    if (last_step) begin
      step_valid_d = 1'b1;
      step_counts_d = quot_next;
      step_dir_d = dir_q;
      rem_d = part_next;
    end
    // Position in counts.
    // The position wraps silently, so the host must home before it can overflow.
    if (step_valid_out) begin
      if (step_dir_out) begin
        motor_pos_d = motor_pos_out - step_ext;
      end else begin
        motor_pos_d = motor_pos_out + step_ext;
      end
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      gear_ratio_numerator_out <= `NUM_RESET;
      gear_ratio_denominator_out <= `DEN_RESET;
    end else begin
      gear_ratio_numerator_out <= num_d;
      gear_ratio_denominator_out <= den_d;
    end
  end

  // The carried remainder is cleared only by reset, not by a ratio change.
  always @(posedge clk_in) begin
    if (srst_in) begin
      state_q <= ST_IDLE;
      dvd_q <= 17'h00000;
      part_q <= 16'h0000;
      quot_q <= 16'h0000;
      bit_q <= 5'h00;
      dir_q <= 1'b0;
      rem_q <= 16'h0000;
    end else begin
      state_q <= state_d;
      dvd_q <= dvd_d;
      part_q <= part_d;
      quot_q <= quot_d;
      bit_q <= bit_d;
      dir_q <= dir_d;
      rem_q <= rem_d;
    end
  end

  always @(posedge clk_in) begin
    if (srst_in) begin
      step_counts_out <= 16'h0000;
      step_valid_out <= 1'b0;
      step_dir_out <= 1'b0;
      motor_pos_out <= 32'h00000000;
    end else begin
      step_counts_out <= step_counts_d;
      step_valid_out <= step_valid_d;
      step_dir_out <= step_dir_d;
      motor_pos_out <= motor_pos_d;
    end
  end
endmodule

/* tb/gear_scaler_assertions.sv */
/* Checker for the gear scaler. Assumes it is bound to the scaler top. */
`timescale 1ns/1ps
module gear_scaler_checker (
  input wire clk_in,
  input wire srst_in,
  input wire ref_pulse_in,
  input wire ref_dir_in,
  input wire num_wr_in,
  input wire [15:0] wr_data_in,
  input wire [1:0] enc_sel_in,
  input wire [15:0] gear_ratio_numerator_out,
  input wire [15:0] gear_ratio_denominator_out,
  input wire [15:0] step_counts_out,
  input wire step_valid_out,
  input wire step_dir_out,
  input wire [31:0] motor_pos_out,
  input wire [17:0] counts_per_rev_out,
  input wire busy_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  sequence s_take; ref_pulse_in && !busy_out; endsequence
  sequence s_work; busy_out[*8] ##1 busy_out[*8] ##1 busy_out ##1 !busy_out; endsequence
  property p_rst; $past(srst_in) |-> gear_ratio_numerator_out == 16'h0004
    && gear_ratio_denominator_out == 16'h0001; endproperty
  property p_wr; num_wr_in && !busy_out && wr_data_in != 16'h0000
    |=> gear_ratio_numerator_out == $past(wr_data_in); endproperty
  property p_cpr; counts_per_rev_out == (enc_sel_in == 2'h1 ? 18'h10000
    : enc_sel_in == 2'h2 ? 18'h20000 : 18'h02000); endproperty
  property p_work; s_take |=> s_work; endproperty
  property p_lat; s_take |-> ##18 step_valid_out && step_dir_out == $past(ref_dir_in, 18);
  endproperty
  property p_pos; step_valid_out |=> motor_pos_out == ($past(step_dir_out)
    ? $past(motor_pos_out) - $past(step_counts_out)
    : $past(motor_pos_out) + $past(step_counts_out)); endproperty
  a_rst: assert property (p_rst) else $error("bad reset ratio");
  a_wr: assert property (p_wr) else $error("write lost");
  a_cpr: assert property (p_cpr) else $error("bad counts per rev");
  a_work: assert property (p_work) else $error("bad busy span");
  a_lat: assert property (p_lat) else $error("bad step timing");
  a_pos: assert property (p_pos) else $error("bad position");
endmodule
bind electronic_gear_scaler gear_scaler_checker gear_scaler_checker_i(.*);

/* tb/ref_host.sv */
/* Host model sending reference pulses. Assumes busy_in comes from the scaler. */
`timescale 1ns/1ps
module ref_host (
  input wire clk_in,
  input wire busy_in,
  input wire [7:0] n_in,
  input wire dir_in,
  output reg pulse_out = 1'b0,
  output reg dir_out = 1'b0
);
  reg [7:0] sent_q = 8'h00;
  wire fire = !pulse_out && !busy_in && sent_q != n_in;
  always @(posedge clk_in) begin
    pulse_out <= fire;
    sent_q <= sent_q + fire;
    dir_out <= fire ? dir_in : ~dir_out;
  end
endmodule

/* tb/electronic_gear_scaler_bench.sv */
/* Scaler bench: reset, encoder and gearing scenarios. Assumes the ref_host model. */
`timescale 1ns/1ps
module electronic_gear_scaler_bench;
  reg clk_in = 0, srst_in = 1, gdir = 0, nw = 0, dw = 0;
  reg [15:0] wd = 16'h0000;
  reg [1:0] es = 2'h0;
  reg [7:0] tot = 8'h00;
  wire rp, rd, sv, sd, busy;
  wire [15:0] num, den, sc;
  wire [31:0] pos;
  wire [17:0] cpr;
  integer num_errors = 0, cmp_count = 0, i;
  always #5 clk_in = ~clk_in;
  ref_host ref_host_i(.clk_in(clk_in), .busy_in(busy), .n_in(tot), .dir_in(gdir),
    .pulse_out(rp), .dir_out(rd));
  electronic_gear_scaler electronic_gear_scaler_i(.clk_in(clk_in), .srst_in(srst_in),
    .ref_pulse_in(rp), .ref_dir_in(rd), .num_wr_in(nw), .den_wr_in(dw), .wr_data_in(wd),
    .enc_sel_in(es), .gear_ratio_numerator_out(num), .gear_ratio_denominator_out(den),
    .step_counts_out(sc), .step_valid_out(sv), .step_dir_out(sd), .motor_pos_out(pos),
    .counts_per_rev_out(cpr), .busy_out(busy));
  task chk(input string n, input [31:0] s, e); begin
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  end endtask
  task wr(input n, input [15:0] d); begin
    @(posedge clk_in); nw <= n; dw <= !n; wd <= d;
    @(posedge clk_in); nw <= 0; dw <= 0;
    @(posedge clk_in); #1;
  end endtask
  task run(input [7:0] n, input d); begin
    @(posedge clk_in); tot <= tot + n; gdir <= d;
    repeat (n * 20 + 4) @(posedge clk_in);
    #1;
  end endtask
  task t_enc; for (i = 0; i < 4; i = i + 1) begin
    @(posedge clk_in); es <= i[1:0]; #1;
    chk("cpr", cpr, i == 1 ? 32'h10000 : i == 2 ? 32'h20000 : 32'h2000);
  end endtask
  task t_gear; begin
    chk("num", num, 32'h4);
    chk("den", den, 32'h1);
    run(1, 1);
    chk("steps", sc, 32'h4);
    chk("pos", pos, 32'hfffffffc);
    wr(1, 16'h0000);
    chk("num", num, 32'h4);
    // The ratio 3/7 stays in range and reduced, as the configuring side must keep it.
    wr(1, 16'h0003);
    wr(0, 16'h0007);
    chk("den", den, 32'h7);
    run(7, 0);
    chk("steps", sc, 32'h1);
    chk("pos", pos, 32'hffffffff);
  end endtask
  task summarize; begin
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  end endtask
  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 0;
    @(posedge clk_in); #1;
    t_gear;
    t_enc;
    summarize;
  end
  initial begin
    #50000;
    num_errors = num_errors + 1;
    summarize;
  end
endmodule
